// ---- logic/cbr_map.svh ----
// Holds the constants of the bus phase and reset fetch block.
// Assumes inclusion by bare name from the design modules.
`ifndef CBR_MAP_SVH
`define CBR_MAP_SVH

// -----------------------------------------------------------------------------
// Vector addresses
// -----------------------------------------------------------------------------
`define CBR_VEC_LO 16'hfffc
`define CBR_VEC_HI 16'hfffd

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
// Cycle on which the low vector byte is read, counted from reset release.
`define CBR_VEC_CYCLE 3'h6
// System clocks per bus phase.
`define CBR_PHASE_CLKS 2'h2
// Address settle clocks at the start of phase one.
`define CBR_SETTLE_CLKS 2'h1
// Reset value of the data input latch.
`define CBR_DATA_RST 8'h00

`endif

// ---- logic/cbr_pkg.sv ----
// Types shared by the bus phase and reset fetch block.
// Assumes cbr_map.svh is on the include path.
`default_nettype none
package cbr_pkg;
  typedef logic [15:0] cbr_addr_t;
  typedef logic [7:0] cbr_data_t;
  typedef enum logic [4:0]
  {
    CBR_RESET = 5'b00001,
    CBR_BREAK = 5'b00010,
    CBR_VLO = 5'b00100,
    CBR_VHI = 5'b01000,
    CBR_RUN = 5'b10000
  } cbr_state_e;
endpackage
`default_nettype wire

// ---- logic/cbr_phase_gen.sv ----
// Two-phase non-overlapping clock generator for the bus cycle.
// Assumes a single system clock and synchronous active high reset.
`default_nettype none
`include "cbr_map.svh"
module cbr_phase_gen
(
  input wire logic clk,
  input wire logic reset,
  output logic phase1,
  output logic phase2,
  output logic cycle_end,
  output logic addr_slot
);
  import cbr_pkg::*;

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic ph2_q;
  logic ph2_d;
  logic last_w;

  assign last_w = (cnt_q == `CBR_PHASE_CLKS - 2'h1);
  assign cnt_d = last_w ? 2'h0 : cnt_q + 2'h1;
  assign ph2_d = last_w ? ~ph2_q : ph2_q;
  // The phases are both low on the last clock of each phase so never overlap.
  assign phase1 = ~ph2_q & ~last_w;
  assign phase2 = ph2_q & ~last_w;
  assign cycle_end = ph2_q & last_w;
  assign addr_slot = ~ph2_q & (cnt_q < `CBR_SETTLE_CLKS);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q <= 2'h0;
      ph2_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ph2_q <= ph2_d;
    end
  end

  AST_NO_OVERLAP: assert property (@(posedge clk) disable iff (reset)
    !(phase1 && phase2)) else $error("Phases overlap.");
endmodule
`default_nettype wire

// ---- logic/cbr_top.sv ----
// Processor bus front end: bus phases, reset vector fetch and data latch.
// Assumes memory answers reads combinationally within phase two.
// What this block does
// - Break cycles run first, no program fetch.
// - Sixth cycle reads FFFC as low byte.
// - Next cycle reads FFFD as high byte.
// - Then fetch starts at assembled vector.
// - Read/write held high during vector fetch.
// - Address changes only early in phase one.
// - Data bus undriven during phase one.
// - Data bus never driven; data_oe held low.
// - Read data latched at phase two end.
// - Both phase clocks driven out.
`default_nettype none
`include "cbr_map.svh"
module cbr_top
(
  input wire logic clk,
  input wire logic reset,
  input wire logic active_low_reset_input_n,
  input wire logic irq_n,
  input wire logic nmi_n,
  input wire cbr_pkg::cbr_data_t data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [15:0] addr,
  output logic read_write,
  output logic phase1_out,
  output logic phase2_out,
  output logic opcode_fetch,
  output logic [15:0] start_addr
);
  import cbr_pkg::*;

  // ---------------------------------------------------------------------------
  // Phase generation
  // ---------------------------------------------------------------------------
  logic ph1_w;
  logic ph2_w;
  logic cyc_end_w;
  logic addr_slot_w;

  cbr_phase_gen u_phase
  (
    .clk(clk),
    .reset(reset),
    .phase1(ph1_w),
    .phase2(ph2_w),
    .cycle_end(cyc_end_w),
    .addr_slot(addr_slot_w)
  );
  assign phase1_out = ph1_w;
  assign phase2_out = ph2_w;

  // ---------------------------------------------------------------------------
  // Start-up sequencer
  // ---------------------------------------------------------------------------
  cbr_state_e state_q;
  cbr_state_e state_d;
  logic [2:0] cyc_q;
  logic [2:0] cyc_d;
  logic [7:0] vec_lo_q;
  logic [7:0] vec_lo_d;
  cbr_addr_t pc_q;
  cbr_addr_t pc_d;
  cbr_addr_t addr_q;
  cbr_addr_t addr_d;
  cbr_data_t din_q;
  logic held_w;
  logic brk_last_w;
  cbr_addr_t next_addr_w;

  assign held_w = ~active_low_reset_input_n;
  assign brk_last_w = (cyc_q == `CBR_VEC_CYCLE - 3'h1);

  always_comb
  begin
    state_d = state_q;
    cyc_d = cyc_q;
    vec_lo_d = vec_lo_q;
    pc_d = pc_q;
    if (held_w)
    begin
      state_d = CBR_RESET;
      cyc_d = 3'h0;
    end
    else if (cyc_end_w)
    begin
      unique case (state_q)
        CBR_RESET:
        begin
          state_d = CBR_BREAK;
          cyc_d = 3'h1;
        end
        CBR_BREAK:
        begin
          cyc_d = cyc_q + 3'h1;
          if (brk_last_w)
            state_d = CBR_VLO;
        end
        CBR_VLO:
        begin
          // Vector bytes come from the latch filled as phase two ended.
          vec_lo_d = din_q;
          state_d = CBR_VHI;
        end
        CBR_VHI:
        begin
          pc_d = {din_q, vec_lo_q};
          state_d = CBR_RUN;
        end
        CBR_RUN:
          pc_d = pc_q + 16'h0001;
      endcase
    end
  end

  assign next_addr_w = (state_q == CBR_VLO) ? `CBR_VEC_LO :
                       (state_q == CBR_VHI) ? `CBR_VEC_HI :
                       (state_q == CBR_RUN) ? pc_q : 16'h0100;
  // Address moves only in the settle slot.
  assign addr_d = addr_slot_w ? next_addr_w : addr_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= CBR_RESET;
      cyc_q <= 3'h0;
      vec_lo_q <= `CBR_DATA_RST;
      pc_q <= 16'h0000;
      addr_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      vec_lo_q <= vec_lo_d;
      pc_q <= pc_d;
      addr_q <= addr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Data bus
  // ---------------------------------------------------------------------------
  // Latch at phase two end.
  // The edge that closes phase two takes the byte, as memory may stop driving then.
  always_ff @(posedge clk)
  begin
    if (reset)
      din_q <= `CBR_DATA_RST;
    else if (ph2_w)
      din_q <= data_in;
  end

  assign addr = addr_q;
  // Read only in this front end.
  assign read_write = 1'b1;
  assign data_oe = 1'b0;
  assign data_out = din_q;
  assign opcode_fetch = (state_q == CBR_RUN);
  assign start_addr = pc_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  AST_NO_FETCH_EARLY: assert property (@(posedge clk) disable iff (reset)
    $rose(opcode_fetch) |-> $past(state_q) == CBR_VHI) else $error("Early fetch.");
  AST_VEC_LO: assert property (@(posedge clk) disable iff (reset)
    (state_q == CBR_VLO && ph2_w) |-> addr == `CBR_VEC_LO) else $error("Bad lo.");
  AST_VEC_HI: assert property (@(posedge clk) disable iff (reset)
    (state_q == CBR_VLO && cyc_end_w && !held_w) |=> state_q == CBR_VHI)
    else $error("No hi fetch.");
  AST_JUMP: assert property (@(posedge clk) disable iff (reset)
    (state_q == CBR_VHI && ph2_w && !held_w) ##1 !held_w |=>
    start_addr == {$past(data_in, 2), vec_lo_q}) else $error("Bad vector.");
  AST_READ: assert property (@(posedge clk) disable iff (reset)
    (state_q inside {CBR_VLO, CBR_VHI}) |-> read_write) else $error("Not read.");
  AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (reset)
    !addr_slot_w |=> $stable(addr)) else $error("Address moved late.");
  AST_NO_DRIVE_PH1: assert property (@(posedge clk) disable iff (reset)
    ph1_w |-> !data_oe) else $error("Driven in phase one.");
  AST_LATCH: assert property (@(posedge clk) disable iff (reset)
    ph2_w |=> data_out == $past(data_in)) else $error("Latch missed.");
  AST_LATCH_KEEP: assert property (@(posedge clk) disable iff (reset)
    !ph2_w |=> $stable(data_out)) else $error("Latch moved outside phase two.");
  AST_HOLD: assert property (@(posedge clk) disable iff (reset)
    held_w |=> state_q == CBR_RESET) else $error("Counted in reset.");
  AST_HOLD_NO_FETCH: assert property (@(posedge clk) disable iff (reset)
    held_w |=> !opcode_fetch) else $error("Fetch while held.");

  // ---------------------------------------------------------------------------
  // Start-up order checks
  // ---------------------------------------------------------------------------
  // The vector read must follow exactly five break cycles.
  AST_VEC_CYCLE: assert property (@(posedge clk) disable iff (reset)
    (state_q == CBR_VLO && $past(state_q) == CBR_BREAK) |->
    $past(cyc_q) == `CBR_VEC_CYCLE - 3'h1) else $error("Vector read off cycle.");
  AST_HI_ADDR: assert property (@(posedge clk) disable iff (reset)
    (state_q == CBR_VHI && ph2_w) |-> addr == `CBR_VEC_HI) else $error("Bad hi.");
  AST_RUN_ADDR: assert property (@(posedge clk) disable iff (reset)
    (state_q == CBR_RUN && ph2_w) |-> addr == start_addr) else $error("Fetch off pc.");

  // ---------------------------------------------------------------------------
  // Phase checks
  // ---------------------------------------------------------------------------
  // Every phase one pulse is followed by phase two two clocks later.
  AST_PH_ORDER: assert property (@(posedge clk) disable iff (reset)
    $rose(phase1_out) |-> ##2 phase2_out) else $error("Phase two missing.");

  // ---------------------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------------------
  COV_LO: cover property (@(posedge clk) state_q == CBR_VLO);
  COV_HI: cover property (@(posedge clk) state_q == CBR_VHI);
  COV_RUN: cover property (@(posedge clk) state_q == CBR_RUN);
  COV_HELD_BREAK: cover property (@(posedge clk) state_q == CBR_BREAK && held_w);
endmodule
`default_nettype wire

// ---- tb/cbr_rom_model.sv ----
// Boot memory model that answers processor reads on the parallel bus.
// Assumes phase two marks the window in which the memory drives the bus.
`default_nettype none
module cbr_rom_model
(
  input wire logic clk,
  input wire logic phase2,
  input wire logic [15:0] addr,
  input wire logic [15:0] vec,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_q;
  logic [7:0] word;
  assign word = (addr == 16'hfffc) ? vec[7:0] :
    (addr == 16'hfffd) ? vec[15:8] : addr[7:0] ^ addr[15:8];
  // Drive only in phase two; otherwise show the inverse of the last byte.
  assign data = phase2 ? word : ~last_q;
  always_ff @(posedge clk)
  begin
    if (phase2)
    begin
      last_q <= word;
    end
  end
endmodule
`default_nettype wire

// ---- tb/cbr_top_test.sv ----
// Testbench for the bus phase and reset vector fetch block.
// Assumes the boot memory model answers every read.
`default_nettype none
module cbr_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cbr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic res_n = 1'b0;
  logic [15:0] vec = 16'h0000;
  cbr_data_t data_in;
  logic [7:0] data_out;
  logic data_oe, read_write, phase1_out, phase2_out, opcode_fetch;
  logic [15:0] addr, start_addr;
  int n_errors = 0;
  int checked = 0;
  // Each row: vector in memory {high, low}, then the expected start address.
  logic [31:0] rows [4] = '{32'h8000_8000, 32'hfffc_fffc, 32'h0000_0000, 32'h12a5_12a5};

  cbr_top u_dut
  (
    .clk(clk), .reset(reset), .active_low_reset_input_n(res_n),
    .irq_n(1'b1), .nmi_n(1'b1), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .addr(addr), .read_write(read_write),
    .phase1_out(phase1_out), .phase2_out(phase2_out),
    .opcode_fetch(opcode_fetch), .start_addr(start_addr)
  );
  cbr_rom_model u_rom
  (
    .clk(clk), .phase2(phase2_out), .addr(addr), .vec(vec), .data(data_in)
  );

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic run_boot(input logic [31:0] row);
    logic [15:0] q [$];
    logic [7:0] d [$];
    logic f [$];
    logic prev_p2;
    logic [15:0] prev_a;
    int idx;
    @(negedge clk);
    vec = row[31:16];
    res_n = 1'b0;
    repeat (12) @(negedge clk);
    check("held fetch", {15'h0, opcode_fetch}, 16'h0);
    // Release just before the edge that closes a bus cycle, so the count starts clean.
    for (int k = 0; k < 8 && !phase2_out; k++)
      @(negedge clk);
    check("phase wait", {15'h0, phase2_out}, 16'h1);
    @(negedge clk);
    res_n = 1'b1;
    prev_p2 = 1'b0;
    prev_a = 16'h0;
    idx = -1;
    repeat (64)
    begin
      @(negedge clk);
      if (prev_p2)
        check("addr hold", addr, prev_a);
      check("overlap", {15'h0, phase1_out & phase2_out}, 16'h0);
      check("rw oe", {14'h0, read_write, data_oe}, 16'h2);
      if (phase2_out)
      begin
        q.push_back(addr);
        d.push_back(data_out);
        f.push_back(opcode_fetch);
      end
      prev_p2 = phase2_out;
      prev_a = addr;
    end
    foreach (q[i])
      if (idx < 0 && q[i] === 16'hfffc)
        idx = i;
    check("vector slot", {15'h0, idx == 5 && q.size() > idx + 2}, 16'h1);
    if (idx >= 0 && q.size() > idx + 2)
    begin
      for (int i = 0; i < idx; i++)
        check("early fetch", {15'h0, f[i]}, 16'h0);
      check("high addr", q[idx + 1], 16'hfffd);
      check("start addr", q[idx + 2], row[15:0]);
      check("low byte", {8'h0, d[idx + 1]}, {8'h0, row[23:16]});
      check("high byte", {8'h0, d[idx + 2]}, {8'h0, row[31:24]});
    end
    $display("boot %h done", row[15:0]);
  endtask

  initial
  begin
    repeat (16) @(negedge clk);
    check("reset addr", addr, 16'h0000);
    check("reset data", {8'h0, data_out}, 16'h0000);
    check("reset fetch", {15'h0, opcode_fetch}, 16'h0);
    reset = 1'b0;
    @(negedge clk);
    $display("reset test done");
    foreach (rows[i])
      run_boot(rows[i]);
    // Pin pulled, released, then pulled again in the middle of the break cycles.
    res_n = 1'b0;
    repeat (4) @(negedge clk);
    res_n = 1'b1;
    repeat (10) @(negedge clk);
    check("break fetch", {15'h0, opcode_fetch}, 16'h0);
    run_boot(32'h5a3c_5a3c);
    end_sim();
  end
endmodule
`default_nettype wire
